// >>> mdu_muldiv_unit.sv
`timescale 1ns/10ps
module mdu_muldiv_unit
    import mdu_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        issue_valid,     // Operation offered this cycle
    input  wire mdu_req_t    issue_req,       // Operation and operands
    output logic             issue_stall,     // Integer pipeline must hold issue
    output logic [31:0]      result_high,     // High result register
    output logic [31:0]      result_low,      // Low result register
    output logic             hilo_valid,      // Result registers updated (pulse)
    output logic [31:0]      gpr_result,      // Product for general register
    output logic             gpr_valid,       // General-register product ready (pulse)
    output logic             div_busy         // Divide in progress
);

    // Controller states
    typedef enum logic [2:0] {
        MDU_ST_IDLE = 3'b001,
        MDU_ST_MUL2 = 3'b010,
        MDU_ST_DIV  = 3'b100
    } mdu_state_t;

    // Second operand fits a sign- or zero-extended 16-bit slice
    function automatic logic mdu_is_short(input logic [31:0] v, input logic sgn);
        mdu_is_short = sgn ? (v[31:15] == {17{v[15]}}) : (v[31:16] == 16'h0000);
    endfunction : mdu_is_short

    // Signed ops decoded in several places
    function automatic logic mdu_is_signed(input mdu_op_t op);
        mdu_is_signed = (op == MDU_OP_MUL_S) || (op == MDU_OP_MAC_S) || (op == MDU_OP_MSB_S) ||
                        (op == MDU_OP_MUL_GPR) || (op == MDU_OP_DIV_S);
    endfunction : mdu_is_signed

    mdu_state_t  state_reg;        // Controller state
    logic [63:0] acc_reg;          // {result_high, result_low}
    logic [63:0] part_reg;         // First-pass partial product
    mdu_req_t    hold_reg;         // Operation held for second pass
    logic [5:0]  iter_reg;         // Remaining divide iterations
    logic [31:0] quo_reg;          // Shifting dividend / quotient
    logic [32:0] rem_reg;          // Partial remainder
    logic [31:0] dvs_reg;          // Divisor magnitude
    logic        neg_q_reg;        // Quotient sign fix-up
    logic        neg_r_reg;        // Remainder sign fix-up
    logic [1:0]  wait_reg;         // Settling cycles left before iterating
    logic        gpr_pend_reg;     // Extra write-back stage for GPR product
    logic [31:0] gpr_stage_reg;    // Staged GPR product

    logic        is_div;           // Incoming divide
    logic        is_mul;           // Incoming product of any kind
    logic        sgn;              // Incoming signedness
    logic        short_op;         // Incoming short second operand
    logic        accept;           // Operation taken this cycle
    logic [63:0] pass_prod;        // One array pass result
    logic [63:0] full_prod;        // Completed product
    logic        prod_done;        // Product finishes this cycle
    mdu_req_t    prod_req;         // Request owning finishing product
    logic [31:0] dvd_abs;          // Dividend magnitude
    logic [5:0]  skip;             // Early-in skip count
    logic [1:0]  pad;              // Settling cycles for this dividend width
    logic [32:0] rem_try;          // Trial subtraction
    logic [31:0] quo_step;         // Quotient after this step
    logic [32:0] rem_step;         // Remainder after this step
    logic        div_last;         // Last quotient bit resolves this cycle

    assign is_div   = (issue_req.op == MDU_OP_DIV_S) || (issue_req.op == MDU_OP_DIV_U);
    assign is_mul   = (issue_req.op != MDU_OP_NONE) && !is_div;
    assign sgn      = mdu_is_signed(issue_req.op);
    // Only the second operand decides the pass count, sized by hardware
    assign short_op = mdu_is_short(issue_req.second_operand, sgn);

    // Stall while second pass or divide runs; the unit itself keeps going
    assign issue_stall = issue_valid && (issue_req.op != MDU_OP_NONE) &&
                         (state_reg != MDU_ST_IDLE);
    assign accept   = issue_valid && (issue_req.op != MDU_OP_NONE) && (state_reg == MDU_ST_IDLE);
    assign div_busy = (state_reg == MDU_ST_DIV);

    // One pass: 32-bit first operand times a 16-bit slice of the second
    always_comb begin
        logic signed [32:0] a;
        logic signed [16:0] b;
        logic signed [49:0] p;
        mdu_req_t           r;
        a = '0;
        b = '0;
        p = '0;
        r = (state_reg == MDU_ST_MUL2) ? hold_reg : issue_req;
        a = {mdu_is_signed(r.op) & r.first_operand[31], r.first_operand};
        if (state_reg == MDU_ST_MUL2) begin
            // Upper slice carries the sign
            b = {mdu_is_signed(r.op) & r.second_operand[31], r.second_operand[31:16]};
        end else if (short_op) begin
            b = {mdu_is_signed(r.op) & r.second_operand[15], r.second_operand[15:0]};
        end else begin
            // Lower slice is always unsigned in a two-pass product
            b = {1'b0, r.second_operand[15:0]};
        end
        p = a * b;
        pass_prod = {{14{p[49]}}, p};
    end

    // Completion of a product, shifted second pass added to first
    always_comb begin
        prod_req  = (state_reg == MDU_ST_MUL2) ? hold_reg : issue_req;
        prod_done = (state_reg == MDU_ST_MUL2) || (accept && is_mul && short_op);
        full_prod = (state_reg == MDU_ST_MUL2) ? (part_reg + {pass_prod[47:0], 16'h0000}) : pass_prod;
    end

    // Early-in detection on dividend magnitude
    always_comb begin
        dvd_abs = (sgn && issue_req.first_operand[31]) ? (32'h0 - issue_req.first_operand)
                                                       : issue_req.first_operand;
        // Narrow dividends settle longer so each width meets its stated latency
        if (dvd_abs[31:8] == 24'h000000) begin
            skip = MDU_SKIP_8;
            pad  = MDU_PAD_8;
        end else if (dvd_abs[31:16] == 16'h0000) begin
            skip = MDU_SKIP_16;
            pad  = MDU_PAD_16;
        end else if (dvd_abs[31:24] == 8'h00) begin
            skip = MDU_SKIP_24;
            pad  = MDU_PAD_NONE;
        end else begin
            skip = 6'h00;
            pad  = MDU_PAD_NONE;
        end
    end

    assign rem_try = {rem_reg[31:0], quo_reg[31]} - {1'b0, dvs_reg};
    // One restoring step; negative trial keeps the shifted remainder
    assign quo_step = {quo_reg[30:0], !rem_try[32]};
    assign rem_step = rem_try[32] ? {rem_reg[31:0], quo_reg[31]} : rem_try;
    // Final bit and result write share one edge, saving a fix-up cycle
    assign div_last = (state_reg == MDU_ST_DIV) && (wait_reg == 2'h0) && (iter_reg == 6'h01);

    // Controller; divide takes skip-reduced iterations plus settling cycles for narrow dividends
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= MDU_ST_IDLE;
        end else begin
            case (state_reg)
                MDU_ST_IDLE: begin
                    if (accept && is_div) begin
                        state_reg <= MDU_ST_DIV;
                    end else if (accept && !short_op) begin
                        state_reg <= MDU_ST_MUL2;
                    end
                end
                MDU_ST_MUL2: state_reg <= MDU_ST_IDLE; // Repeat 2 for full width
                MDU_ST_DIV: begin
                    if (div_last) begin
                        state_reg <= MDU_ST_IDLE;
                    end
                end
                default:     state_reg <= MDU_ST_IDLE;
            endcase
        end
    end

    // First-pass capture for two-pass products
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            part_reg <= MDU_ACC_RESET;
            hold_reg <= '0;
        end else if (accept && is_mul && !short_op) begin
            part_reg <= pass_prod;
            hold_reg <= issue_req;
        end
    end

    // Divider datapath: one quotient bit per clock
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            iter_reg    <= 6'h00;
            quo_reg     <= 32'h0;
            rem_reg     <= 33'h0;
            dvs_reg     <= 32'h0;
            neg_q_reg   <= 1'b0;
            neg_r_reg   <= 1'b0;
            wait_reg    <= 2'h0;
        end else if (accept && is_div) begin
            // Pre-shift the dividend past skipped leading bits
            iter_reg    <= MDU_DIV_ITERS - skip;
            quo_reg     <= dvd_abs << skip;
            rem_reg     <= 33'h0;
            dvs_reg     <= (sgn && issue_req.second_operand[31]) ?
                           (32'h0 - issue_req.second_operand) : issue_req.second_operand;
            neg_q_reg   <= sgn && (issue_req.first_operand[31] ^ issue_req.second_operand[31]);
            neg_r_reg   <= sgn && issue_req.first_operand[31];
            wait_reg    <= pad;
        end else if (state_reg == MDU_ST_DIV && wait_reg != 2'h0) begin
            // Settling cycle, no quotient bit yet
            wait_reg    <= wait_reg - 2'h1;
        end else if (state_reg == MDU_ST_DIV && iter_reg != 6'h00) begin
            // Restoring step; divide by zero result is unspecified
            rem_reg     <= rem_step;
            quo_reg     <= quo_step;
            iter_reg    <= iter_reg - 6'h01;
        end
    end

    // Result registers: products, accumulate/deduct, divide results
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg    <= MDU_ACC_RESET;
            hilo_valid <= 1'b0;
        end else begin
            hilo_valid <= 1'b0;
            if (prod_done && prod_req.op != MDU_OP_MUL_GPR) begin
                hilo_valid <= 1'b1;
                case (prod_req.op)
                    MDU_OP_MAC_S, MDU_OP_MAC_U: acc_reg <= acc_reg + full_prod;
                    MDU_OP_MSB_S, MDU_OP_MSB_U: acc_reg <= acc_reg - full_prod;
                    default:                    acc_reg <= full_prod;
                endcase
            end else if (div_last) begin
                hilo_valid <= 1'b1;
                acc_reg[31:0]  <= neg_q_reg ? (32'h0 - quo_step) : quo_step;
                acc_reg[63:32] <= neg_r_reg ? (32'h0 - rem_step[31:0]) : rem_step[31:0];
            end
        end
    end

    // General-register product takes one extra write-back stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            gpr_pend_reg  <= 1'b0;
            gpr_stage_reg <= 32'h0;
            gpr_result    <= 32'h0;
            gpr_valid     <= 1'b0;
        end else begin
            gpr_pend_reg  <= prod_done && (prod_req.op == MDU_OP_MUL_GPR);
            gpr_stage_reg <= full_prod[31:0];
            gpr_valid     <= gpr_pend_reg;
            if (gpr_pend_reg) begin
                gpr_result <= gpr_stage_reg;
            end
        end
    end

    assign result_high = acc_reg[63:32];
    assign result_low  = acc_reg[31:0];

endmodule : mdu_muldiv_unit

// >>> mdu_pkg.sv
package mdu_pkg;
    // Operation codes issued by the integer pipeline
    typedef enum logic [3:0] {
        MDU_OP_NONE      = 4'h0,
        MDU_OP_MUL_S     = 4'h1, // product_signed
        MDU_OP_MUL_U     = 4'h2, // product_unsigned
        MDU_OP_MAC_S     = 4'h3, // product_accumulate_signed
        MDU_OP_MAC_U     = 4'h4, // product_accumulate_unsigned
        MDU_OP_MSB_S     = 4'h5, // product_deduct_signed
        MDU_OP_MSB_U     = 4'h6, // product_deduct_unsigned
        MDU_OP_MUL_GPR   = 4'h7, // product to general register
        MDU_OP_DIV_S     = 4'h8, // quotient_signed
        MDU_OP_DIV_U     = 4'h9  // quotient_unsigned
    } mdu_op_t;

    // Issue request bundle
    typedef struct packed {
        mdu_op_t     op;
        logic [31:0] first_operand;
        logic [31:0] second_operand;
    } mdu_req_t;

    // Datapath widths and divider timing
    localparam int          MDU_W          = 32;
    localparam int          MDU_SLICE_W    = 16;
    localparam logic [5:0]  MDU_DIV_ITERS  = 6'h20; // Full 32 iterations
    localparam logic [5:0]  MDU_SKIP_8     = 6'h17; // 23 skipped
    localparam logic [5:0]  MDU_SKIP_16    = 6'h0F; // 15 skipped
    localparam logic [5:0]  MDU_SKIP_24    = 6'h07; // 7 skipped
    localparam logic [1:0]  MDU_PAD_8      = 2'h2;  // Settling cycles, 8-bit dividend
    localparam logic [1:0]  MDU_PAD_16     = 2'h1;  // Settling cycles, 16-bit dividend
    localparam logic [1:0]  MDU_PAD_NONE   = 2'h0;  // No settling for wider dividends
    localparam logic [63:0] MDU_ACC_RESET  = 64'h0000_0000_0000_0000;
endpackage : mdu_pkg

// >>> mdu_muldiv_unit_chk.sv
`timescale 1ns/10ps
module mdu_muldiv_unit_chk
    import mdu_pkg::*;
(
    input wire logic     core_clk,
    input wire logic     arst_n,
    input wire logic     issue_valid,
    input wire mdu_req_t issue_req,
    input wire logic     issue_stall,
    input wire logic     hilo_valid,
    input wire logic     gpr_valid,
    input wire logic     div_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic        sgn; // Signed reading
    logic        tk;  // Offer taken
    logic        f16; // Short second operand
    logic        hl;  // Result register product
    logic        a8;  // Dividend fits 8 bits
    logic        a32; // Dividend needs 32 bits
    logic [31:0] a;
    logic [31:0] b;
    mdu_op_t     op;
    assign op  = issue_req.op;
    assign a   = issue_req.first_operand;
    assign b   = issue_req.second_operand;
    assign sgn = op inside {MDU_OP_MUL_S, MDU_OP_MAC_S, MDU_OP_MSB_S, MDU_OP_MUL_GPR, MDU_OP_DIV_S};
    assign tk  = issue_valid && !issue_stall && op != MDU_OP_NONE;
    assign hl  = op inside {[MDU_OP_MUL_S:MDU_OP_MSB_U]};
    // Size from value only, sign or zero extension
    assign f16 = sgn ? (b[31:15] == {17{b[15]}}) : (b[31:16] == 16'h0000);
    assign a8  = sgn ? (a[31:7] == {25{a[7]}}) : (a[31:8] == 24'h000000);
    assign a32 = sgn ? (a[31:23] != {9{a[23]}}) : (a[31:24] != 8'h00);
    sequence s_short; tk && hl && f16; endsequence
    sequence s_full; tk && hl && !f16; endsequence
    sequence s_div8; tk && op >= MDU_OP_DIV_S && a8; endsequence
    sequence s_div32; tk && op >= MDU_OP_DIV_S && a32; endsequence
    property p_stall_cause; issue_stall |-> issue_valid && op != MDU_OP_NONE; endproperty
    a_stall_cause: assert property (p_stall_cause) else $error("stall without offer");
    property p_div_hold; div_busy && issue_valid && op != MDU_OP_NONE |-> issue_stall; endproperty
    a_div_hold: assert property (p_div_hold) else $error("offer taken in divide");
    property p_short_lat; s_short |=> hilo_valid; endproperty
    a_short_lat: assert property (p_short_lat) else $error("short product late");
    property p_full_lat; s_full |=> !hilo_valid ##1 hilo_valid; endproperty
    a_full_lat: assert property (p_full_lat) else $error("full product timing");
    property p_full_block; s_full |=> (issue_valid && op != MDU_OP_NONE) |-> issue_stall; endproperty
    a_full_block: assert property (p_full_block) else $error("no stall after full");
    property p_gpr; tk && op == MDU_OP_MUL_GPR |-> (f16 ##2 gpr_valid) or (!f16 ##2 !gpr_valid ##1 gpr_valid); endproperty
    a_gpr: assert property (p_gpr) else $error("register product timing");
    property p_div8; s_div8 |=> div_busy[*8] ##3 div_busy ##1 hilo_valid; endproperty
    a_div8: assert property (p_div8) else $error("short divide timing");
    property p_div32; s_div32 |-> ##32 div_busy ##1 hilo_valid; endproperty
    a_div32: assert property (p_div32) else $error("full divide timing");
endmodule : mdu_muldiv_unit_chk
bind mdu_muldiv_unit mdu_muldiv_unit_chk u_mdu_muldiv_unit_chk (.core_clk(core_clk), .arst_n(arst_n),
    .issue_valid(issue_valid), .issue_req(issue_req), .issue_stall(issue_stall),
    .hilo_valid(hilo_valid), .gpr_valid(gpr_valid), .div_busy(div_busy));

// >>> mdu_issue_model.sv
`timescale 1ns/10ps
module mdu_issue_model
    import mdu_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic issue_stall,
    output mdu_req_t  issue_req,
    output logic      issue_valid
);
    initial begin
        issue_valid = 1'b0;
        issue_req   = '0;
    end
    // Hold the offer until an edge sees no stall
    task automatic send(input mdu_req_t r, output int w);
        logic st;
        w           = -1;
        issue_valid = 1'b1;
        issue_req   = r;
        for (int i = 0; i < 64; i++) begin
            @(negedge core_clk);
            st = issue_stall;
            @(posedge core_clk);
            #1;
            if (st === 1'b0) begin
                w = i;
                break;
            end
        end
    endtask : send
    // Inverted operands so stale values never pass
    task automatic idle();
        issue_valid = 1'b0;
        issue_req   = ~issue_req;
    endtask : idle
endmodule : mdu_issue_model

// >>> mdu_muldiv_unit_test.sv
`timescale 1ns/10ps
module mdu_muldiv_unit_test;
    import mdu_pkg::*;
    typedef struct {int due; logic [63:0] val;} mdu_exp_t;
    logic [31:0] result_high, result_low, gpr_result;
    logic        core_clk, arst_n, issue_valid, issue_stall, hilo_valid, gpr_valid, div_busy;
    mdu_req_t    issue_req;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cyc = 0;      // Edge counter
    logic [63:0] acc;          // Model of both result registers
    mdu_exp_t    hq[$], gq[$]; // Pending results
    mdu_exp_t    e, g;
    mdu_muldiv_unit u_mdu_muldiv_unit (.core_clk(core_clk), .arst_n(arst_n), .issue_valid(issue_valid),
        .issue_req(issue_req), .issue_stall(issue_stall), .result_high(result_high), .result_low(result_low),
        .hilo_valid(hilo_valid), .gpr_result(gpr_result), .gpr_valid(gpr_valid), .div_busy(div_busy));
    mdu_issue_model u_mdu_issue_model (.core_clk(core_clk), .issue_stall(issue_stall),
        .issue_req(issue_req), .issue_valid(issue_valid));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // Pulses looked at mid-cycle, once settled; due is the edge that samples them
    always @(negedge core_clk) begin
        if (arst_n && hilo_valid !== 1'b0) begin
            e = (hq.size() != 0) ? hq.pop_front() : mdu_exp_t'{-1, 64'h0};
            check(64'(cyc + 1), 64'(e.due));
            check({result_high, result_low}, e.val);
        end
        if (arst_n && gpr_valid !== 1'b0) begin
            g = (gq.size() != 0) ? gq.pop_front() : mdu_exp_t'{-1, 64'h0};
            check(64'(cyc + 1), 64'(g.due));
            check({32'h00000000, gpr_result}, g.val);
        end
    end
    task automatic issue(input mdu_op_t op, input logic [31:0] a, input logic [31:0] b, input int st);
        int          w, lat;
        logic        s, fit;
        logic [63:0] p;
        s   = op inside {MDU_OP_MUL_S, MDU_OP_MAC_S, MDU_OP_MSB_S, MDU_OP_MUL_GPR, MDU_OP_DIV_S};
        fit = s ? (b[31:15] == {17{b[15]}}) : (b[31:16] == 16'h0000);
        p   = {{32{s & a[31]}}, a} * {{32{s & b[31]}}, b};
        u_mdu_issue_model.send('{op, a, b}, w);
        if (w < 0) begin
            fail_count++;
            complete_run();
        end
        if (st == -2) check(64'(w != 0), 64'h1);
        else check(64'(w), 64'(st));
        case (op)
            MDU_OP_MUL_S, MDU_OP_MUL_U: acc = p;
            MDU_OP_MAC_S, MDU_OP_MAC_U: acc = acc + p;
            MDU_OP_MSB_S, MDU_OP_MSB_U: acc = acc - p;
            MDU_OP_MUL_GPR: gq.push_back(mdu_exp_t'{cyc + (fit ? 2 : 3), {32'h00000000, p[31:0]}});
            default: acc = s ? {$signed(a) % $signed(b), $signed(a) / $signed(b)} : {a % b, a / b};
        endcase
        lat = fit ? 1 : 2;
        if (op >= MDU_OP_DIV_S) lat = (a < 32'h80) ? 12 : (a < 32'h8000) ? 19 : (a < 32'h800000) ? 26 : 33;
        if (op != MDU_OP_MUL_GPR) hq.push_back(mdu_exp_t'{cyc + lat, acc});
    endtask : issue
    initial begin
        int k;
        arst_n = 1'b0;
        acc    = MDU_ACC_RESET;
        k      = $urandom(32'h97379DF9);
        repeat (5) @(posedge core_clk);
        #1 arst_n = 1'b1;
        for (k = 0; k < 6; k++) issue(mdu_op_t'(k + 1), $urandom, $urandom & 32'h7FFF, 0);
        // Bit 31 clear and bit 16 set: never a short operand, signed or not
        for (k = 0; k < 6; k++) issue(mdu_op_t'(k + 1), $urandom, $urandom & 32'h7FFFFFFF | 32'h10000, k != 0);
        issue(MDU_OP_MUL_GPR, $urandom, $urandom | 32'hFFFF8000, 1);
        issue(MDU_OP_MUL_GPR, $urandom, $urandom & 32'h7FFFFFFF | 32'h10000, 0);
        issue(MDU_OP_MUL_U, $urandom, 32'h0000FFFF, 1);
        // Divides of each dividend width, signed and unsigned
        for (k = 0; k < 8; k++) issue(k[0] ? MDU_OP_DIV_U : MDU_OP_DIV_S, $urandom & (32'hFFFFFFFF >> (25 - 8 * (k / 2))),
            $urandom_range(255, 1) | (k[1] ? 32'hFFFFFF00 : 32'h0), (k == 0) ? 0 : -2);
        issue(MDU_OP_MSB_S, $urandom, 32'h00000003, -2);
        u_mdu_issue_model.idle();
        for (k = 0; k < 60 && hq.size() + gq.size() != 0; k++) @(posedge core_clk);
        check(64'(hq.size() + gq.size()), 64'h0);
        complete_run();
    end
endmodule : mdu_muldiv_unit_test
